// >>> hw/bst_pkg.sv
package bst_pkg;
    // Instruction register shape
    localparam int IR_LEN = 10;
    localparam logic [9:0] IR_CAPTURE = 10'h001;
    // Opcodes
    localparam logic [9:0] OP_EXTEST = 10'h000;
    localparam logic [9:0] OP_SAMPLE = 10'h055;
    localparam logic [9:0] OP_IDCODE = 10'h059;
    localparam logic [9:0] OP_USERCODE = 10'h079;
    localparam logic [9:0] OP_CFG_LOAD = 10'h002;
    localparam logic [9:0] OP_BYPASS = 10'h3ff;
    // Data register widths and positions
    localparam int DR_LEN = 32;
    localparam int CFG_LEN = 8;
    localparam int CFG_LSB = DR_LEN - CFG_LEN;
    localparam int USER_LEN = 7;
    localparam int FIXED_LEN = 25;
    // Defaults
    localparam int BSR_LEN_DEF = 438;
    localparam int FIFO_DEPTH = 8;
    // Power-on clear: 50 us at 8 ns
    localparam int POR_TIME_US = 50;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int POR_CYCLES = POR_TIME_US * 1000000 / CLK_PERIOD_PS;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // Controller states, one-hot
    typedef enum logic [15:0] {
        ST_RESET = 16'h0001,
        ST_IDLE = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PAU_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PAU_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } bst_state_e;

    // Scan pin bundle
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bst_scan_s;
endpackage

// >>> hw/bst_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser for asynchronous levels
module bst_sync #(
    parameter int W = 1
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            meta <= '0;
            q_out <= '0;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule

// >>> hw/bst_fifo.sv
`timescale 1ns/10ps
// Flop FIFO, honest full and empty
module bst_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_out = (count != DEPTH[AW:0]);
    assign out_valid_out = (count != '0);
    assign out_data_out = mem[rd_ptr];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    // Storage
    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    // Pointers wrap at depth
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// >>> hw/bst_tap.sv
`timescale 1ns/10ps
// Operation
// R1: Standard test port, decoder and registers
// R2: No scan testing while configuration runs
// R3: SAMPLE captures pins, allows preload
// R4: EXTEST drives cells, captures input pins
// R5: BYPASS gives one-bit stage
// R6: USERCODE shifts user signature out
// R7: IDCODE shifts identification value out
// R8: Configuration instructions load data through port
// R9: Instruction register is ten bits
// R10: Signature is 7 user, 25 fixed
// R11: Boundary length is per-variant parameter
// R12: Power-on clear within fifty microseconds
// R13: Rising TCK steps states; reset selects IDCODE
module bst_tap #(
    parameter int BSR_LEN = bst_pkg::BSR_LEN_DEF, // R11
    parameter int POR_CYCLES = bst_pkg::POR_CYCLES,
    parameter logic [31:0] ID_VALUE = 32'h0000_0001, // Arbitrary value
    parameter logic [6:0] USER_BITS = 7'h00,
    parameter logic [24:0] USER_FIXED = 25'h000_0000, // Arbitrary value
    parameter int FIFO_W = bst_pkg::CFG_LEN,
    parameter int FIFO_D = bst_pkg::FIFO_DEPTH
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    input wire logic [BSR_LEN-1:0] pin_in,
    input wire logic [BSR_LEN-1:0] core_out_in,
    output logic [BSR_LEN-1:0] pin_out,
    input wire logic config_active_in,
    output logic [FIFO_W-1:0] cfg_data_out,
    output logic cfg_valid_out,
    input wire logic cfg_ready_in,
    output logic por_done_out
);
    bst_pkg::bst_state_e state;
    bst_pkg::bst_state_e next_state;
    bst_pkg::bst_scan_s scan_raw;
    bst_pkg::bst_scan_s scan;
    logic [BSR_LEN-1:0] pin_s;
    logic tck_prev;
    logic tck_rise;
    logic tck_fall;
    logic step;
    logic [bst_pkg::IR_LEN-1:0] ir;
    logic [bst_pkg::IR_LEN-1:0] ir_sh;
    logic [bst_pkg::DR_LEN-1:0] dr_sh;
    logic [BSR_LEN-1:0] bsr_sh;
    logic [BSR_LEN-1:0] bsr_upd;
    logic bypass_bit;
    logic [$clog2(POR_CYCLES+1)-1:0] por_cnt;
    logic por_done;
    logic sel_bsr;
    logic sel_extest;
    logic sel_id;
    logic sel_user;
    logic sel_cfg;
    logic cfg_pend;
    logic [FIFO_W-1:0] cfg_byte;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [FIFO_W-1:0] fifo_out_data;
    logic fifo_pop;
    logic serial_bit;

    // Scan pins and boundary pins come from outside
    assign scan_raw = '{tck: tck_in, tms: tms_in, tdi: tdi_in};

    bst_sync #(
        .W(3)
    ) u_scan_sync (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .d_in(scan_raw),
        .q_out(scan)
    );

    bst_sync #(
        .W(BSR_LEN)
    ) u_pin_sync (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .d_in(pin_in),
        .q_out(pin_s)
    );

    // Edge finder on the synchronised scan clock
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            tck_prev <= 1'b0;
        end else begin
            tck_prev <= scan.tck;
        end
    end

    assign tck_rise = scan.tck & ~tck_prev;
    assign tck_fall = ~scan.tck & tck_prev;
    // Pending byte freezes the port until the FIFO takes it
    assign step = tck_rise & ~cfg_pend & por_done;

    // Power-on clear counter
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            por_cnt <= '0;
            por_done <= 1'b0;
        end else if (!por_done) begin
            por_cnt <= por_cnt + 1'b1;
            if (por_cnt == ($bits(por_cnt))'(POR_CYCLES - 1)) begin
                por_done <= 1'b1; // R12
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            por_done_out <= 1'b0;
        end else begin
            por_done_out <= por_done;
        end
    end

    // Instruction decode; scan test muted during configuration
    always_comb begin
        sel_bsr = (ir == bst_pkg::OP_SAMPLE) | (ir == bst_pkg::OP_EXTEST);
        sel_bsr = sel_bsr & ~config_active_in; // R2
        sel_extest = (ir == bst_pkg::OP_EXTEST) & ~config_active_in; // R2
        sel_id = (ir == bst_pkg::OP_IDCODE); // R7
        sel_user = (ir == bst_pkg::OP_USERCODE); // R6
        sel_cfg = (ir == bst_pkg::OP_CFG_LOAD); // R8
    end

    // Test port state transitions
    always_comb begin
        next_state = state;
        case (state)
            bst_pkg::ST_RESET: begin
                next_state = scan.tms ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
            end
            bst_pkg::ST_IDLE: begin
                next_state = scan.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            end
            bst_pkg::ST_SEL_DR: begin
                next_state = scan.tms ? bst_pkg::ST_SEL_IR
                                      : bst_pkg::ST_CAP_DR;
            end
            bst_pkg::ST_CAP_DR: begin
                next_state = scan.tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
            end
            bst_pkg::ST_SH_DR: begin
                next_state = scan.tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
            end
            bst_pkg::ST_EX1_DR: begin
                next_state = scan.tms ? bst_pkg::ST_UPD_DR
                                      : bst_pkg::ST_PAU_DR;
            end
            bst_pkg::ST_PAU_DR: begin
                next_state = scan.tms ? bst_pkg::ST_EX2_DR
                                      : bst_pkg::ST_PAU_DR;
            end
            bst_pkg::ST_EX2_DR: begin
                next_state = scan.tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
            end
            bst_pkg::ST_UPD_DR: begin
                next_state = scan.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            end
            bst_pkg::ST_SEL_IR: begin
                next_state = scan.tms ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
            end
            bst_pkg::ST_CAP_IR: begin
                next_state = scan.tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
            end
            bst_pkg::ST_SH_IR: begin
                next_state = scan.tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
            end
            bst_pkg::ST_EX1_IR: begin
                next_state = scan.tms ? bst_pkg::ST_UPD_IR
                                      : bst_pkg::ST_PAU_IR;
            end
            bst_pkg::ST_PAU_IR: begin
                next_state = scan.tms ? bst_pkg::ST_EX2_IR
                                      : bst_pkg::ST_PAU_IR;
            end
            bst_pkg::ST_EX2_IR: begin
                next_state = scan.tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
            end
            bst_pkg::ST_UPD_IR: begin
                next_state = scan.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            end
            default: begin
                next_state = bst_pkg::ST_RESET;
            end
        endcase
    end

    // State register, held in reset until power-on clear ends
    always_ff @(posedge mclk_in) begin
        if (rst_in || !por_done) begin
            state <= bst_pkg::ST_RESET; // R12
        end else if (step) begin
            state <= next_state; // R13
        end
    end

    // Instruction shift and update
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ir_sh <= '0;
            ir <= bst_pkg::OP_IDCODE;
        end else if (state == bst_pkg::ST_RESET) begin
            ir <= bst_pkg::OP_IDCODE; // R13
        end else begin
            if (step && state == bst_pkg::ST_CAP_IR) begin
                ir_sh <= bst_pkg::IR_CAPTURE;
            end else if (step && state == bst_pkg::ST_SH_IR) begin
                ir_sh <= {scan.tdi, ir_sh[bst_pkg::IR_LEN-1:1]}; // R9
            end
            if (tck_fall && state == bst_pkg::ST_UPD_IR) begin
                ir <= ir_sh; // R1
            end
        end
    end

    // Bypass stage
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            bypass_bit <= 1'b0;
        end else if (step && state == bst_pkg::ST_CAP_DR) begin
            bypass_bit <= 1'b0;
        end else if (step && state == bst_pkg::ST_SH_DR) begin
            bypass_bit <= scan.tdi; // R5
        end
    end

    // Identification, signature and configuration shifter
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            dr_sh <= '0;
        end else if (step && state == bst_pkg::ST_CAP_DR) begin
            if (sel_id) begin
                dr_sh <= ID_VALUE; // R7
            end else if (sel_user) begin
                dr_sh <= {USER_FIXED, USER_BITS}; // R10
            end else begin
                // Configuration status seen on capture
                dr_sh <= {{(bst_pkg::CFG_LEN-2){1'b0}}, ~fifo_in_ready,
                          config_active_in, {bst_pkg::CFG_LSB{1'b0}}};
            end
        end else if (step && state == bst_pkg::ST_SH_DR) begin
            dr_sh <= {scan.tdi, dr_sh[bst_pkg::DR_LEN-1:1]}; // R6
        end
    end

    // Boundary cells: shift path and update latch
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            bsr_sh <= '0;
            bsr_upd <= '0;
        end else begin
            if (step && sel_bsr && state == bst_pkg::ST_CAP_DR) begin
                bsr_sh <= pin_s; // R3 R4
            end else if (step && sel_bsr && state == bst_pkg::ST_SH_DR) begin
                bsr_sh <= {scan.tdi, bsr_sh[BSR_LEN-1:1]}; // R11
            end
            if (tck_fall && sel_bsr && state == bst_pkg::ST_UPD_DR) begin
                bsr_upd <= bsr_sh; // R3
            end
        end
    end

    // Pins follow the core unless EXTEST holds them
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pin_out <= '0;
        end else begin
            pin_out <= sel_extest ? bsr_upd : core_out_in; // R4
        end
    end

    // Configuration byte hand-off; a new byte is taken only while none is pending
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cfg_pend <= 1'b0;
            cfg_byte <= bst_pkg::CFG_RESET;
        end else if (tck_fall && sel_cfg && state == bst_pkg::ST_UPD_DR
                     && !cfg_pend) begin
            cfg_pend <= 1'b1; // R8
            cfg_byte <= dr_sh[bst_pkg::DR_LEN-1:bst_pkg::CFG_LSB];
        end else if (cfg_pend && fifo_in_ready) begin
            cfg_pend <= 1'b0;
        end
    end

    bst_fifo #(
        .W(FIFO_W),
        .DEPTH(FIFO_D)
    ) u_cfg_fifo (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .in_valid_in(cfg_pend),
        .in_ready_out(fifo_in_ready),
        .in_data_in(cfg_byte),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_out_data)
    );

    // Output stage keeps the stream registered
    assign fifo_pop = fifo_out_valid & (~cfg_valid_out | cfg_ready_in);

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cfg_valid_out <= 1'b0;
            cfg_data_out <= '0;
        end else if (fifo_pop) begin
            cfg_valid_out <= 1'b1;
            cfg_data_out <= fifo_out_data;
        end else if (cfg_ready_in) begin
            cfg_valid_out <= 1'b0;
        end
    end

    // Serial output selection
    always_comb begin
        if (state == bst_pkg::ST_SH_IR) begin
            serial_bit = ir_sh[0];
        end else if (sel_bsr) begin
            serial_bit = bsr_sh[0];
        end else if (sel_id || sel_user) begin
            serial_bit = dr_sh[0];
        end else if (sel_cfg) begin
            serial_bit = dr_sh[bst_pkg::CFG_LSB]; // Eight-bit path
        end else begin
            serial_bit = bypass_bit; // R5
        end
    end

    // Output changes on falling scan clock, per the standard
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            tdo_out <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else if (tck_fall) begin
            tdo_out <= serial_bit; // R1
            tdo_oe_out <= (state == bst_pkg::ST_SH_DR)
                          | (state == bst_pkg::ST_SH_IR);
        end
    end
endmodule

// >>> testbench/bst_tap_assertions.sv
`timescale 1ns/10ps
// Port-level watch on the scan port block
module bst_tap_checker #(
    parameter int BSR_LEN = 438,
    parameter int POR_CYCLES = 20,
    parameter int FIFO_W = 8
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic tck_in,
    input wire logic tdo_out,
    input wire logic tdo_oe_out,
    input wire logic [BSR_LEN-1:0] core_out_in,
    input wire logic [BSR_LEN-1:0] pin_out,
    input wire logic [FIFO_W-1:0] cfg_data_out,
    input wire logic cfg_valid_out,
    input wire logic cfg_ready_in,
    input wire logic por_done_out
);
    logic [15:0] rel_cnt;
    // Cycles since release; saturates so long runs never wrap
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rel_cnt <= 16'h0000;
        end else if (rel_cnt != 16'hffff) begin
            rel_cnt <= rel_cnt + 16'h0001;
        end
    end
    // Each check but chk_scan_held and chk_oe_span ties an output to its cause at the inputs
    chk_reset_quiet: assert property (@(posedge mclk_in)
        disable iff (rst_in) $fell(rst_in) |-> !por_done_out
        && !cfg_valid_out && !tdo_oe_out && pin_out == '0)
        else $error("outputs not clear after reset");
    chk_por_time: assert property (@(posedge mclk_in)
        disable iff (rst_in) por_done_out == (rel_cnt > 16'(POR_CYCLES)))
        else $error("power-on clear length wrong");
    chk_scan_held: assert property (@(posedge mclk_in)
        disable iff (rst_in) !por_done_out |-> !tdo_oe_out && !cfg_valid_out)
        else $error("scan active before clear done");
    chk_pins_follow: assert property (@(posedge mclk_in)
        disable iff (rst_in) !por_done_out && !$past(rst_in)
        |-> pin_out == $past(core_out_in))
        else $error("pins not following core");
    chk_tdo_on_fall: assert property (@(posedge mclk_in)
        disable iff (rst_in) por_done_out && $changed(tdo_out) |-> !tck_in)
        else $error("serial out moved while clock high");
    chk_oe_on_fall: assert property (@(posedge mclk_in)
        disable iff (rst_in) $changed(tdo_oe_out) |-> !tck_in && !$past(tck_in))
        else $error("output enable moved while clock high");
    chk_oe_span: assert property (@(posedge mclk_in)
        disable iff (rst_in) $rose(tdo_oe_out) |-> tdo_oe_out [*8])
        else $error("shift window too short");
    chk_cfg_holds: assert property (@(posedge mclk_in)
        disable iff (rst_in) cfg_valid_out && !cfg_ready_in
        |=> cfg_valid_out && $stable(cfg_data_out))
        else $error("config byte dropped before accept");
endmodule

bind bst_tap bst_tap_checker #(.BSR_LEN(BSR_LEN),
    .POR_CYCLES(POR_CYCLES), .FIFO_W(FIFO_W)) i_chk (
    .mclk_in(mclk_in), .rst_in(rst_in), .tck_in(tck_in),
    .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
    .core_out_in(core_out_in), .pin_out(pin_out),
    .cfg_data_out(cfg_data_out), .cfg_valid_out(cfg_valid_out),
    .cfg_ready_in(cfg_ready_in), .por_done_out(por_done_out));

// >>> testbench/bst_tester.sv
`timescale 1ns/10ps
// Scan tester; link clock stands low outside frames
module bst_tester #(
    parameter int SCAN_W = 438
) (
    input wire logic mclk_in,
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    input wire logic tdo_in
);
    // Idle mode and data lines sit at their pull-up level; clock low
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
    end
    // One 80 ns link period; serial out read at the rise
    task automatic step(input logic m, input logic d, output logic q);
        @(negedge mclk_in);
        tms_out = m;
        tdi_out = d;
        repeat (4) @(negedge mclk_in);
        tck_out = 1'b1;
        q = tdo_in;
        repeat (5) @(negedge mclk_in);
        tck_out = 1'b0;
    endtask
    // Five ones reach reset from any state, then park in idle
    task automatic tap_reset();
        logic q;
        repeat (5) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
    // Idle to idle scan, first bit shifted is bit 0
    task automatic scan(input logic is_ir, input int n,
        input logic [SCAN_W-1:0] din, output logic [SCAN_W-1:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b1, q);
        if (is_ir) begin
            step(1'b1, 1'b1, q);
        end
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        tms_out = 1'b1;
        tdi_out = 1'b1;
    endtask
endmodule

// >>> testbench/tb.sv
`timescale 1ns/10ps
// Self-checking bench for the scan port block
module tb;
    localparam int BSR = 438;
    localparam int PORC = 20;
    localparam logic [31:0] IDV = 32'h0c3a_5e21; // Arbitrary value
    localparam logic [6:0] UBITS = 7'h5a;
    localparam logic [24:0] UFIX = 25'h0b1_c2d3; // Arbitrary value
    localparam logic [BSR-1:0] PAT_A = {146{3'b011}};
    localparam logic [BSR-1:0] PAT_B = {219{2'b10}};
    localparam logic [BSR-1:0] PAT_C = {73{6'b100101}};
    logic mclk, rst, tck, tms, tdi, tdo, tdo_oe, tdo_w, por_done;
    logic cfg_active, cfg_ready, cfg_valid;
    logic [7:0] cfg_data;
    logic [BSR-1:0] pins, core, pin_drv, dout;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    // Released serial out shows no stale level
    assign tdo_w = tdo_oe ? tdo : ~tdo;
    bst_tap #(.BSR_LEN(BSR), .POR_CYCLES(PORC), .ID_VALUE(IDV),
        .USER_BITS(UBITS), .USER_FIXED(UFIX)) i_dut (
        .mclk_in(mclk), .rst_in(rst), .tck_in(tck), .tms_in(tms),
        .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .pin_in(pins),
        .core_out_in(core), .pin_out(pin_drv),
        .config_active_in(cfg_active), .cfg_data_out(cfg_data),
        .cfg_valid_out(cfg_valid), .cfg_ready_in(cfg_ready),
        .por_done_out(por_done));
    bst_tester #(.SCAN_W(BSR)) i_tester (.mclk_in(mclk), .tck_out(tck),
        .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_w));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Hang guard; a full run needs about 13000 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [BSR-1:0] want,
        input logic [BSR-1:0] got);
        n_compared++;
        if (got !== want) begin
            $display("ERROR %s expected %h seen %h", what, want, got);
            errors++;
        end
    endtask
    task automatic stop_test();
        if (errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Identification value straight after a controller reset
    task automatic t_idcode();
        i_tester.tap_reset();
        i_tester.scan(1'b0, 32, '1, dout);
        check("idcode", BSR'(IDV), BSR'(dout[31:0]));
    endtask
    // Instruction capture pattern, then the user signature
    task automatic t_usercode();
        i_tester.scan(1'b1, 10, BSR'(bst_pkg::OP_USERCODE), dout);
        check("ir", BSR'(bst_pkg::IR_CAPTURE), BSR'(dout[9:0]));
        i_tester.scan(1'b0, 32, '0, dout);
        check("user", BSR'({UFIX, UBITS}), BSR'(dout[31:0]));
    endtask
    // One-stage delay with a zero captured ahead; pins stay normal
    task automatic t_bypass(input logic [9:0] op, input logic act);
        cfg_active = act;
        i_tester.scan(1'b1, 10, BSR'(op), dout);
        i_tester.scan(1'b0, 4, BSR'(4'b1011), dout);
        check("bypass", BSR'(4'b0110), BSR'(dout[3:0]));
        check("pins_core", core, pin_drv);
        cfg_active = 1'b0;
    endtask
    // Snapshot and preload, then drive the preload and read pins back
    task automatic t_boundary();
        i_tester.scan(1'b1, 10, BSR'(bst_pkg::OP_SAMPLE), dout);
        i_tester.scan(1'b0, BSR, PAT_C, dout);
        check("sample", PAT_A, dout);
        check("pins_normal", PAT_B, pin_drv);
        i_tester.scan(1'b1, 10, BSR'(bst_pkg::OP_EXTEST), dout);
        check("extest_drive", PAT_C, pin_drv);
        pins = ~PAT_A;
        i_tester.scan(1'b0, BSR, PAT_C, dout);
        check("extest_capture", ~PAT_A, dout);
        check("extest_hold", PAT_C, pin_drv);
        i_tester.tap_reset();
        check("pins_after_reset", PAT_B, pin_drv);
    endtask
    // Queue bytes until the buffer refuses, then drain with stalls
    task automatic t_config();
        i_tester.scan(1'b1, 10, BSR'(bst_pkg::OP_CFG_LOAD), dout);
        // Output stage plus eight slots hold nine; the tenth waits pending
        for (int k = 0; k < 10; k++) begin
            cfg_active = (k == 9);
            i_tester.scan(1'b0, 8, BSR'(8'ha0 + 8'(k)), dout);
            if (k == 0) check("stat0", '0, BSR'(dout[1:0]));
            if (k == 9) check("stat9", BSR'(2'b11), BSR'(dout[1:0]));
        end
        cfg_active = 1'b0;
        for (int k = 0; k < 10; k++) begin
            repeat (3) @(negedge mclk);
            for (int w = 0; w < 20 && cfg_valid !== 1'b1; w++) @(negedge mclk);
            check("byte", BSR'({1'b1, 8'ha0 + 8'(k)}),
                BSR'({cfg_valid, cfg_data}));
            cfg_ready = 1'b1;
            @(negedge mclk);
            cfg_ready = 1'b0;
        end
        repeat (10) @(negedge mclk);
        check("cfg_empty", '0, BSR'(cfg_valid));
    endtask
    // Main sequence: reset, clear time, then each scenario
    initial begin
        rst = 1'b1;
        cfg_active = 1'b0;
        cfg_ready = 1'b0;
        pins = PAT_A;
        core = PAT_B;
        repeat (5) @(negedge mclk);
        check("por_in_reset", '0, BSR'(por_done));
        rst = 1'b0;
        repeat (PORC) @(negedge mclk);
        check("por_early", '0, BSR'(por_done));
        @(negedge mclk);
        check("por_done", BSR'(1'b1), BSR'(por_done));
        t_idcode();
        t_usercode();
        t_bypass(bst_pkg::OP_BYPASS, 1'b0);
        t_bypass(bst_pkg::OP_SAMPLE, 1'b1);
        t_bypass(bst_pkg::OP_EXTEST, 1'b1);
        t_boundary();
        t_config();
        t_idcode();
        stop_test();
    end
endmodule
